// ===== design/pgss_regs.v
`timescale 1ns/1ps
`include "pgss_defines.vh"
// Power-good turn-off threshold, soft-start rise time and fault summary
module pgss_regs (
  input wire i_mclk,
  input wire i_srst,
  input wire i_cmd_wr,
  input wire i_cmd_rd,
  input wire [7:0] i_cmd_code,
  input wire [15:0] i_wr_data,
  input wire [15:0] i_pg_on_threshold,
  input wire i_pg_on_upd,
  input wire [15:0] i_loop_scale_factor,
  input wire i_store_req,
  input wire i_clear_faults,
  input wire i_comm_fault,
  input wire i_other_comm_fault,
  input wire i_vout_ov,
  input wire i_iout_oc,
  input wire i_over_temp,
  input wire i_vin_uv,
  input wire i_vout_uv,
  input wire i_conv_enabled,
  output reg [15:0] o_rd_data,
  output reg o_rd_ack,
  output reg o_rd_nack,
  output reg o_wr_ack,
  output reg o_wr_nack,
  output reg [15:0] o_pg_off_threshold,
  output reg [1:0] o_pg_window_sel,
  output reg [15:0] o_rise_time,
  output reg [2:0] o_rise_sel,
  output reg o_rise_fast,
  output reg [7:0] o_fault_summary,
  output reg o_comm_invalid_data,
  output reg o_smb_alert_o,
  output reg o_smb_alert_oe,
  output reg o_nvm_store,
  output reg [15:0] o_nvm_pg_off,
  output reg [15:0] o_nvm_rise
);
  wire [`PGSS_PIN_W-1:0] pins_sync;
  wire wr_pg_off;
  wire wr_rise;
  wire [31:0] ratio_prod;
  wire [10:0] rise_mant;
  reg [1:0] next_sel;
  reg range_err;
  reg [2:0] next_rise_sel;
  reg [10:0] next_rise_mant;
  reg pg_check;
  reg [7:0] next_summary;
  reg comm_evt;
  reg inval_evt;

  // Fault and enable pins come from the analog side; enable goes in inverted
  // so that the cleared synchroniser reads as enabled and the off bit stays low after reset
  pgss_sync #(
    .W(`PGSS_PIN_W)
  ) u_pin_sync (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_async({~i_conv_enabled, i_vout_uv, i_vin_uv, i_over_temp, i_iout_oc, i_vout_ov}),
    .o_sync(pins_sync)
  );

  // Command decode for writes
  assign wr_pg_off = i_cmd_wr && (i_cmd_code == `PGSS_CMD_PG_OFF);
  assign wr_rise = i_cmd_wr && (i_cmd_code == `PGSS_CMD_RISE);

  // Requested volts times loop scale, compared as percent of reference
  assign ratio_prod = {17'h0_0000, i_wr_data[`PGSS_PG_WR_MSB:0]} * {16'h0000, i_loop_scale_factor};
  assign rise_mant = i_wr_data[`PGSS_RISE_MANT_MSB:0];

  // Snap requested lower limit to a supported pair, clamp at the extremes
  always @* begin
    next_sel = `PGSS_SEL_90;
    range_err = 1'b0;
    if (i_wr_data[`PGSS_PG_SIGN]) begin
      next_sel = `PGSS_SEL_88; // Negative request is far too low
      range_err = 1'b1;
    end else if (ratio_prod >= `PGSS_LIM_HIGH) begin
      next_sel = `PGSS_SEL_92;
      range_err = 1'b1;
    end else if (ratio_prod >= `PGSS_MID_92_90) begin
      next_sel = `PGSS_SEL_92;
    end else if (ratio_prod >= `PGSS_MID_90_88) begin
      next_sel = `PGSS_SEL_90;
    end else if (ratio_prod >= `PGSS_LIM_LOW) begin
      next_sel = `PGSS_SEL_88;
    end else begin
      next_sel = `PGSS_SEL_88;
      range_err = 1'b1;
    end
  end

  // Nearest supported rise time, zero kept as fastest start
  always @* begin
    next_rise_sel = 3'h0;
    if (rise_mant < `PGSS_RISE_M01) begin
      next_rise_sel = 3'h0;
    end else if (rise_mant < `PGSS_RISE_M12) begin
      next_rise_sel = 3'h1;
    end else if (rise_mant < `PGSS_RISE_M23) begin
      next_rise_sel = 3'h2;
    end else if (rise_mant < `PGSS_RISE_M34) begin
      next_rise_sel = 3'h3;
    end else if (rise_mant < `PGSS_RISE_M45) begin
      next_rise_sel = 3'h4;
    end else if (rise_mant < `PGSS_RISE_M56) begin
      next_rise_sel = 3'h5;
    end else if (rise_mant < `PGSS_RISE_M67) begin
      next_rise_sel = 3'h6;
    end else begin
      next_rise_sel = 3'h7;
    end
    case (next_rise_sel)
      3'h0: next_rise_mant = `PGSS_RISE_V0;
      3'h1: next_rise_mant = `PGSS_RISE_V1;
      3'h2: next_rise_mant = `PGSS_RISE_V2;
      3'h3: next_rise_mant = `PGSS_RISE_V3;
      3'h4: next_rise_mant = `PGSS_RISE_V4;
      3'h5: next_rise_mant = `PGSS_RISE_V5;
      3'h6: next_rise_mant = `PGSS_RISE_V6;
      default: next_rise_mant = `PGSS_RISE_V7;
    endcase
    if (rise_mant == 11'h000) begin
      next_rise_mant = 11'h000;
    end
  end

  // Stored threshold word, sign bit held clear
  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_pg_off_threshold <= `PGSS_PG_OFF_RST;
    end else if (wr_pg_off) begin
      o_pg_off_threshold <= {1'b0, i_wr_data[`PGSS_PG_WR_MSB:0]}; // Top bit reads zero
    end
  end

  // Window pair follows every write, a clamped one too
  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_pg_window_sel <= `PGSS_SEL_90; // Forced, independent of loop scale
    end else if (wr_pg_off) begin
      o_pg_window_sel <= next_sel; // Lower and upper limit move together
    end
  end

  // Rise time register and its setting index
  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_rise_time <= {`PGSS_RISE_EXP, `PGSS_RISE_MANT_RST};
      o_rise_sel <= `PGSS_RISE_SEL_RST;
    end else if (wr_rise) begin
      o_rise_time <= {`PGSS_RISE_EXP, next_rise_mant}; // Exponent stays fixed
      o_rise_sel <= next_rise_sel;
    end
  end

  // Fastest-start flag, kept apart from the index since zero has no index of its own
  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_rise_fast <= 1'b0;
    end else if (wr_rise) begin
      o_rise_fast <= (rise_mant == 11'h000);
    end
  end

  // Consistency check runs the cycle after either threshold changes
  always @(posedge i_mclk) begin
    if (i_srst) begin
      pg_check <= 1'b0;
    end else begin
      pg_check <= wr_pg_off | i_pg_on_upd;
    end
  end

  // Communication events for this cycle
  always @* begin
    inval_evt = (wr_pg_off && range_err) || (pg_check && (i_pg_on_threshold <= o_pg_off_threshold));
    comm_evt = inval_evt || i_comm_fault;
  end

  // Summary byte: sticky faults, set beats clear
  always @* begin
    next_summary = o_fault_summary;
    if (i_clear_faults) begin
      next_summary = `PGSS_SB_RST;
    end
    next_summary[`PGSS_SB_OFF] = pins_sync[`PGSS_PIN_EN]; // Live, synchronised disabled level
    if (pins_sync[`PGSS_PIN_OV]) begin
      next_summary[`PGSS_SB_VOUT_OV] = 1'b1;
    end
    if (pins_sync[`PGSS_PIN_OC]) begin
      next_summary[`PGSS_SB_IOUT_OC] = 1'b1;
    end
    if (pins_sync[`PGSS_PIN_TEMP]) begin
      next_summary[`PGSS_SB_TEMP] = 1'b1;
    end
    if (pins_sync[`PGSS_PIN_VIN_UV]) begin
      next_summary[`PGSS_SB_VIN_UV] = 1'b1;
    end
    if (pins_sync[`PGSS_PIN_VOUT_UV] || i_other_comm_fault) begin
      next_summary[`PGSS_SB_OTHER] = 1'b1;
    end
    if (comm_evt) begin
      next_summary[`PGSS_SB_CML] = 1'b1;
    end
  end

  // Summary byte register
  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_fault_summary <= `PGSS_SB_RST;
    end else begin
      o_fault_summary <= next_summary;
    end
  end

  // Invalid-data flag, a new event beats a clear in the same cycle
  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_comm_invalid_data <= 1'b0;
    end else if (inval_evt) begin
      o_comm_invalid_data <= 1'b1;
    end else if (i_clear_faults) begin
      o_comm_invalid_data <= 1'b0;
    end
  end

  // Open-drain alert: data always low, the enable pulls the line
  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_smb_alert_o <= 1'b0;
      o_smb_alert_oe <= 1'b0;
    end else begin
      o_smb_alert_o <= 1'b0;
      if (comm_evt) begin
        o_smb_alert_oe <= 1'b1; // Pull the alert line low
      end else if (i_clear_faults) begin
        o_smb_alert_oe <= 1'b0;
      end
    end
  end

  // Register reads and write acknowledges
  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_rd_data <= 16'h0000;
      o_rd_ack <= 1'b0;
      o_rd_nack <= 1'b0;
      o_wr_ack <= 1'b0;
      o_wr_nack <= 1'b0;
    end else begin
      o_rd_ack <= 1'b0;
      o_rd_nack <= 1'b0;
      // Out-of-range data is still acknowledged
      o_wr_ack <= wr_pg_off | wr_rise;
      o_wr_nack <= i_cmd_wr & ~(wr_pg_off | wr_rise);
      if (i_cmd_rd) begin
        case (i_cmd_code)
          `PGSS_CMD_PG_OFF: begin
            o_rd_data <= o_pg_off_threshold;
            o_rd_ack <= 1'b1;
          end
          `PGSS_CMD_RISE: begin
            o_rd_data <= o_rise_time;
            o_rd_ack <= 1'b1;
          end
          `PGSS_CMD_SUMMARY: begin
            o_rd_data <= {8'h00, o_fault_summary};
            o_rd_ack <= 1'b1;
          end
          default: begin
            o_rd_data <= 16'h0000;
            o_rd_nack <= 1'b1;
          end
        endcase
      end
    end
  end

  // Store request echoed to the memory controller one cycle later
  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_nvm_store <= 1'b0;
    end else begin
      o_nvm_store <= i_store_req;
    end
  end

  // Snapshot of both registers as they stood at the request
  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_nvm_pg_off <= 16'h0000;
      o_nvm_rise <= 16'h0000;
    end else if (i_store_req) begin
      o_nvm_pg_off <= o_pg_off_threshold;
      o_nvm_rise <= o_rise_time;
    end
  end
endmodule

// ===== design/pgss_defines.vh
// What this block does
// - Command 5Fh selects power-good turn-off threshold
// - One write sets both window limits
// - Snap to 92/108, 90/110 or 88/112
// - Threshold word is linear, exponent minus ten
// - Turn-on at or below turn-off flags fault
// - Out-of-range write: acknowledge, flag, clamp to extreme
// - Two bytes, bit 15 read-only
// - Reset threshold about 1.08 V, 90% pair
// - Command 61h selects rise time, snapped
// - Eight rise times, default 2.7 ms
// - Zero rise time means fastest start
// - Exponent fixed minus four, mantissa reset 43
// - Both registers can be stored to NVM
// - Command 78h is read-only summary, resets zero
// - Summary flags overvoltage, overcurrent, temperature, undervoltage
// - Comm faults set comm bit, others catch-all
// - Comm bit means comm, memory or logic fault
// - Off bit set while converter disabled
`ifndef PGSS_DEFINES_VH
`define PGSS_DEFINES_VH

// Command codes
`define PGSS_CMD_PG_OFF 8'h5F
`define PGSS_CMD_RISE 8'h61
`define PGSS_CMD_SUMMARY 8'h78

// Turn-off threshold word
`define PGSS_PG_OFF_RST 16'h0452
`define PGSS_PG_WR_MSB 14
`define PGSS_PG_SIGN 15

// Product of threshold code and loop scale (Q1.15) against percent of 0.6 V, scaled by 2^25
`define PGSS_LIM_HIGH 32'h0120_C49C
`define PGSS_MID_92_90 32'h0117_8D50
`define PGSS_MID_90_88 32'h0111_6873
`define PGSS_LIM_LOW 32'h0108_3127

// Window pair selection codes
`define PGSS_SEL_92 2'h0
`define PGSS_SEL_90 2'h1
`define PGSS_SEL_88 2'h2

// Rise time word: exponent field and mantissa field
`define PGSS_RISE_EXP 5'h1C
`define PGSS_RISE_MANT_MSB 10
`define PGSS_RISE_MANT_RST 11'h02B
`define PGSS_RISE_SEL_RST 3'h4

// Mantissa decision points between neighbouring rise times, in 1/16 ms
`define PGSS_RISE_M01 11'h00C
`define PGSS_RISE_M12 11'h011
`define PGSS_RISE_M23 11'h018
`define PGSS_RISE_M34 11'h024
`define PGSS_RISE_M45 11'h038
`define PGSS_RISE_M56 11'h052
`define PGSS_RISE_M67 11'h078

// Stored mantissa of each supported rise time
`define PGSS_RISE_V0 11'h00A
`define PGSS_RISE_V1 11'h00E
`define PGSS_RISE_V2 11'h013
`define PGSS_RISE_V3 11'h01D
`define PGSS_RISE_V4 11'h02B
`define PGSS_RISE_V5 11'h043
`define PGSS_RISE_V6 11'h060
`define PGSS_RISE_V7 11'h090

// Summary byte bit positions
`define PGSS_SB_OFF 6
`define PGSS_SB_VOUT_OV 5
`define PGSS_SB_IOUT_OC 4
`define PGSS_SB_VIN_UV 3
`define PGSS_SB_TEMP 2
`define PGSS_SB_CML 1
`define PGSS_SB_OTHER 0
`define PGSS_SB_RST 8'h00

// Synchronised pin positions
`define PGSS_PIN_OV 0
`define PGSS_PIN_OC 1
`define PGSS_PIN_TEMP 2
`define PGSS_PIN_VIN_UV 3
`define PGSS_PIN_VOUT_UV 4
`define PGSS_PIN_EN 5
`define PGSS_PIN_W 6

`endif

// ===== design/pgss_sync.v
`timescale 1ns/1ps
// Two-flop synchroniser for a group of independent levels
module pgss_sync #(
  parameter W = 1
) (
  input wire i_mclk,
  input wire i_srst,
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);
  reg [W-1:0] meta;

  // First stage feeds only the second stage
  always @(posedge i_mclk) begin
    if (i_srst) begin
      meta <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule

// ===== bench/pgss_regs_assertions.sv
`timescale 1ns/1ps
// Port-level checker for the register block
module pgss_regs_chk (
  input wire i_mclk,
  input wire i_srst,
  input wire i_cmd_wr,
  input wire i_cmd_rd,
  input wire [7:0] i_cmd_code,
  input wire i_store_req,
  input wire i_clear_faults,
  input wire [15:0] o_rd_data,
  input wire o_rd_ack,
  input wire o_wr_ack,
  input wire o_wr_nack,
  input wire [15:0] o_pg_off_threshold,
  input wire [1:0] o_pg_window_sel,
  input wire [15:0] o_rise_time,
  input wire o_rise_fast,
  input wire [7:0] o_fault_summary,
  input wire o_comm_invalid_data,
  input wire o_smb_alert_oe,
  input wire o_nvm_store,
  input wire [15:0] o_nvm_pg_off
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  property p_thr_ack; i_cmd_wr && i_cmd_code == 8'h5F |=> o_wr_ack; endproperty
  a_thr_ack: assert property (p_thr_ack) else $error("threshold write not taken");
  property p_rise_ack; i_cmd_wr && i_cmd_code == 8'h61 |=> o_wr_ack; endproperty
  a_rise_ack: assert property (p_rise_ack) else $error("rise time write not taken");
  property p_sum_ro; i_cmd_wr && i_cmd_code == 8'h78 |=> o_wr_nack && !o_wr_ack; endproperty
  a_sum_ro: assert property (p_sum_ro) else $error("summary write not refused");
  property p_sum_rd; i_cmd_rd && i_cmd_code == 8'h78 |=> o_rd_ack && o_rd_data[15:7] == 9'h000; endproperty
  a_sum_rd: assert property (p_sum_rd) else $error("summary read wrong");
  property p_bit15; o_pg_off_threshold[15] == 1'b0; endproperty
  a_bit15: assert property (p_bit15) else $error("threshold top bit set");
  property p_pair; o_pg_window_sel != 2'h3; endproperty
  a_pair: assert property (p_pair) else $error("window pair illegal");
  property p_exp; o_rise_time[15:11] == 5'h1C; endproperty
  a_exp: assert property (p_exp) else $error("rise exponent changed");
  property p_fast; o_rise_fast |-> o_rise_time[10:0] == 11'h000; endproperty
  a_fast: assert property (p_fast) else $error("fast start with nonzero time");
  property p_alert; $rose(o_comm_invalid_data) |-> o_smb_alert_oe && o_fault_summary[1]; endproperty
  a_alert: assert property (p_alert) else $error("invalid data without alert");
  property p_sticky; $fell(o_fault_summary[5]) |-> $past(i_clear_faults); endproperty
  a_sticky: assert property (p_sticky) else $error("fault flag dropped");
  property p_store; i_store_req |=> o_nvm_store && o_nvm_pg_off == $past(o_pg_off_threshold); endproperty
  a_store: assert property (p_store) else $error("store snapshot wrong");
  c_alert: cover property ($rose(o_smb_alert_oe));
  c_fast: cover property ($rose(o_rise_fast));
  c_store: cover property (o_nvm_store);
endmodule
bind pgss_regs pgss_regs_chk chk (.*);

// ===== bench/pgss_host.sv
`timescale 1ns/1ps
// Host side of the command bus: one request at a time
module pgss_host (
  input wire i_mclk,
  input wire [15:0] i_rd_data,
  input wire i_rd_ack,
  input wire i_rd_nack,
  input wire i_wr_ack,
  input wire i_wr_nack,
  output reg o_cmd_wr,
  output reg o_cmd_rd,
  output reg [7:0] o_cmd_code,
  output reg [15:0] o_wr_data
);
  initial begin
    o_cmd_wr = 1'b0;
    o_cmd_rd = 1'b0;
    o_cmd_code = 8'h00;
    o_wr_data = 16'h0000;
  end
  // Strobe for one edge; the answer stands in the cycle after it is taken
  task xfer(input logic w, input logic [7:0] c, input logic [15:0] d, output logic [15:0] q,
            output logic [1:0] an);
    @(negedge i_mclk);
    o_cmd_wr = w;
    o_cmd_rd = !w;
    o_cmd_code = c;
    o_wr_data = d;
    @(negedge i_mclk);
    an = w ? {i_wr_ack, i_wr_nack} : {i_rd_ack, i_rd_nack};
    q = i_rd_data;
    o_cmd_wr = 1'b0;
    o_cmd_rd = 1'b0;
    o_wr_data = ~d; // Released data does not keep its value
  endtask
endmodule

// ===== bench/tb_pgss_regs.sv
`timescale 1ns/1ps
module tb_pgss_regs;
  reg i_mclk = 1'b0;
  reg i_srst = 1'b1;
  reg [15:0] i_pg_on_threshold = 16'h7FFF; // Well above every turn-off value the test writes
  reg [15:0] i_loop_scale_factor = 16'h4000; // Programmed before thresholds
  reg [2:0] ctl = 3'h0;
  reg [6:0] flt = 7'h00;
  reg i_conv_enabled = 1'b1;
  wire i_cmd_wr, i_cmd_rd, o_rd_ack, o_rd_nack, o_wr_ack, o_wr_nack, o_rise_fast;
  wire o_comm_invalid_data, o_smb_alert_o, o_smb_alert_oe, o_nvm_store;
  wire [7:0] i_cmd_code, o_fault_summary;
  wire [15:0] i_wr_data, o_rd_data, o_pg_off_threshold, o_rise_time, o_nvm_pg_off, o_nvm_rise;
  wire [1:0] o_pg_window_sel;
  wire [2:0] o_rise_sel;
  wire i_store_req = ctl[0], i_clear_faults = ctl[1], i_pg_on_upd = ctl[2];
  wire i_vout_ov = flt[0], i_iout_oc = flt[1], i_over_temp = flt[2], i_vin_uv = flt[3];
  wire i_vout_uv = flt[4], i_comm_fault = flt[5], i_other_comm_fault = flt[6];
  int n_fail = 0, checks_done = 0, cyc = 0, code, m, s;
  int rv[8] = '{10, 14, 19, 29, 43, 67, 96, 144};
  int fb[7] = '{5, 4, 2, 3, 0, 1, 0};
  int thr_q[$];
  logic [15:0] q;
  logic [1:0] an;
  real p;

  pgss_regs uut (.*);
  pgss_host host (.i_mclk(i_mclk), .i_rd_data(o_rd_data), .i_rd_ack(o_rd_ack), .i_rd_nack(o_rd_nack),
    .i_wr_ack(o_wr_ack), .i_wr_nack(o_wr_nack), .o_cmd_wr(i_cmd_wr), .o_cmd_rd(i_cmd_rd),
    .o_cmd_code(i_cmd_code), .o_wr_data(i_wr_data));

  // Clock and hang guard
  initial forever #2 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test;
    end
  end

  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] c, input logic [15:0] d, input logic [1:0] e);
    host.xfer(1'b1, c, d, q, an);
    chk("wr_answer", {14'h0000, an}, {14'h0000, e});
  endtask
  task rd(input logic [7:0] c, input logic [15:0] e, input logic [1:0] ea);
    host.xfer(1'b0, c, 16'h0000, q, an);
    chk("rd_answer", {14'h0000, an}, {14'h0000, ea});
    chk("rd_data", q, e);
  endtask
  // One-cycle control pulse, answer sampled after the following edge
  task pulse(input int b);
    @(negedge i_mclk);
    ctl[b] = 1'b1;
    @(negedge i_mclk);
    ctl[b] = 1'b0;
    @(negedge i_mclk);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    void'($urandom(77));
    repeat (20) @(negedge i_mclk);
    i_srst = 1'b0;
    rd(8'h5F, 16'h0452, 2'b10);
    chk("sel", {14'h0000, o_pg_window_sel}, 16'h0001);
    rd(8'h61, 16'hE02B, 2'b10);
    chk("rise_sel", {13'h0000, o_rise_sel}, 16'h0004);
    rd(8'h78, 16'h0000, 2'b10);
    // Threshold writes: two far outside, the rest around the window
    for (int i = 0; i < 12; i++) begin
      code = i == 0 ? 512 : i == 1 ? 2000 : 1000 + $urandom % 200;
      thr_q.push_back(code);
      p = code * 16384.0 * 100.0 / (1024.0 * 32768.0 * 0.6);
      s = p >= 91.0 ? 0 : p >= 89.0 ? 1 : 2;
      wr(8'h5F, code[15:0], 2'b10);
      chk("thr", o_pg_off_threshold, code[15:0]);
      chk("sel", {14'h0000, o_pg_window_sel}, s[15:0]);
      chk("invalid", {15'h0000, o_comm_invalid_data}, (p < 86.0 || p >= 94.0) ? 16'h0001 : 16'h0000);
      rd(8'h5F, code[15:0], 2'b10);
      pulse(1);
      chk("cleared", {15'h0000, o_smb_alert_oe}, 16'h0000);
    end
    i_pg_on_threshold = 16'h0000;
    pulse(2);
    @(negedge i_mclk);
    chk("order_fault", {o_fault_summary, 5'h00, o_comm_invalid_data, o_smb_alert_o, o_smb_alert_oe}, 16'h0205);
    i_pg_on_threshold = 16'h7FFF;
    pulse(1);
    // Rise times near each setting, then zero
    for (int k = 0; k < 8; k++) begin
      m = rv[k] + $urandom % 3 - 1;
      wr(8'h61, m[15:0], 2'b10);
      chk("rise", o_rise_time, {5'h1C, rv[k][10:0]});
      chk("rise_sel", {13'h0000, o_rise_sel}, k[15:0]);
    end
    wr(8'h61, 16'h0000, 2'b10);
    chk("fast", {15'h0000, o_rise_fast}, 16'h0001);
    // Each fault source sets its flag, which outlives its cause
    for (int j = 0; j < 7; j++) begin
      flt[j] = 1'b1;
      repeat (4) @(negedge i_mclk);
      flt[j] = 1'b0;
      repeat (4) @(negedge i_mclk);
      rd(8'h78, 16'h0001 << fb[j], 2'b10);
      pulse(1);
      rd(8'h78, 16'h0000, 2'b10);
    end
    i_conv_enabled = 1'b0;
    repeat (4) @(negedge i_mclk);
    rd(8'h78, 16'h0040, 2'b10);
    i_conv_enabled = 1'b1;
    wr(8'h78, 16'h00FF, 2'b01);
    rd(8'h33, 16'h0000, 2'b01);
    pulse(0);
    code = thr_q.pop_back();
    chk("nvm_thr", o_nvm_pg_off, code[15:0]);
    chk("nvm_rise", o_nvm_rise, 16'hE000);
    finish_test;
  end
endmodule
